// >>> dac_pkg.sv
`default_nettype none
package dac_pkg;

  // Register offsets and field positions
  localparam logic [7:0] REG_CHAN     = 8'h04;
  localparam logic [7:0] REG_PINS     = 8'h06;
  localparam int         BIT_FWD_EN   = 0;
  localparam int         BIT_REV_EN   = 1;
  localparam int         BIT_LOCKED   = 7;
  localparam int         BIT_P0_LEVEL = 0;
  localparam int         BIT_P0_DRIVE = 1;
  localparam int         BIT_P1_LEVEL = 2;
  localparam int         BIT_P1_DRIVE = 3;
  localparam int         BIT_SKEW_DIS = 7;

  // Values after reset
  localparam logic       RST_FWD_EN   = 1'b1;
  localparam logic       RST_REV_EN   = 1'b1;
  localparam logic       RST_DRIVE    = 1'b1;
  localparam logic       RST_SKEW_DIS = 1'b0;

  // Timing
  localparam int CLK_KHZ        = 40000;
  localparam int REV_HOLD_US    = 350;
  localparam int REV_HOLD_CYC   = (REV_HOLD_US * CLK_KHZ + 999) / 1000;
  localparam int MAX_RATE_KBPS  = 1000;
  localparam int MIN_BIT_CYC    = CLK_KHZ / MAX_RATE_KBPS;

  // Output group delays in quarter nanoseconds
  localparam logic [2:0] SKEW_G0   = 3'h0;
  localparam logic [2:0] SKEW_G1   = 3'h2;
  localparam logic [2:0] SKEW_G2   = 3'h4;
  localparam logic [2:0] SKEW_G3   = 3'h6;
  localparam logic [2:0] SKEW_PCLK = 3'h3;

  typedef struct packed {
    logic [2:0] grp0;
    logic [2:0] grp1;
    logic [2:0] grp2;
    logic [2:0] grp3;
    logic [2:0] pclk;
  } dac_skew_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dac_bus_type;

endpackage : dac_pkg
`default_nettype wire

// >>> dac_aux_control.sv
// Our own choices: the register addresses and the plain strobed port.
`default_nettype none
// Operation
// [R1] With the serializer side-select low and ours high, both directions carry traffic at once.
// [R2] There is no arbitration on the control link and no acknowledge is made for a collision.
// [R3] Register 0x04 bits 1 and 0 gate the reverse and forward channels; clear stops all traffic.
// [R4] A change of either side-select pin in dual mode restarts the link in the new startup state.
// [R5] The reverse channel is held off for 350 us after every link start or stop.
// [R6] The controller changes the control bit rate by less than 3.5 times per step.
// [R7] After an unclean pixel clock change the host halts the clock 5 us or toggles serialization.
// [R8] The lock output is high only while the video link is locked, never for config link only.
// [R9] Reverse signalling works with no forward link, so the looped lock reaches the far interrupt.
// [R10] Two open-drain pins are driven from register 0x06 bits 3 and 1.
// [R11] Pin input buffers stay on and levels read at register 0x06 bits 2 and 0.
// [R12] Software writes a drive bit to 1 before using that pin as an input.
// [R13] Output skewing is on by default and register 0x06 bit 7 turns it off.
// [R14] Skewed groups delay 0, 0.5, 1, 1.5 ns and pixel clock 0.75 ns, else all zero.
// [R15] Peripheral I2C and UART traffic runs at up to 1 Mbps.
// [R16] Both pin drive bits reset to 1 so the pins are released.
// [R17] Both channel enable bits reset to 1.
module dac_aux_control #(
  parameter int REV_HOLD_CYC = dac_pkg::REV_HOLD_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic [7:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic [7:0]              rdata_o,
  input  wire logic               ser_side_select_i,
  input  wire logic               host_side_select_i,
  output logic                    dual_mode_o,
  output logic                    restart_o,
  input  wire logic               link_active_i,
  input  wire logic               video_locked_i,
  input  wire logic               config_link_i,
  output logic                    lock_o,
  input  wire logic               int_i,
  output logic                    rev_int_o,
  output logic                    rev_avail_o,
  input  wire logic               fwd_uart_i,
  output logic                    fwd_uart_o,
  input  wire logic               rev_uart_i,
  output logic                    rev_uart_o,
  input  wire logic               pin0_i,
  output logic                    pin0_o,
  output logic                    pin0_oe_o,
  input  wire logic               pin1_i,
  output logic                    pin1_o,
  output logic                    pin1_oe_o,
  output dac_pkg::dac_skew_type   skew_o
);

  localparam int HW = $clog2(REV_HOLD_CYC + 1);
  localparam logic [HW-1:0] HOLD_LOAD = HW'(REV_HOLD_CYC);

  logic          fwd_chan_enable;
  logic          rev_chan_enable;
  logic          pin0_drive;
  logic          pin1_drive;
  logic          pin0_level;
  logic          pin1_level;
  logic          skew_disable;
  logic          ser_sel_q;
  logic          host_sel_q;
  logic          link_q;
  logic [HW-1:0] hold_cnt;
  logic [HW-1:0] next_hold_cnt;

  // Register hit test shared by both decodes
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : reg_hit

  // Address decode; any other address reads as zero and ignores writes
  wire sel_chan = reg_hit(addr_i, dac_pkg::REG_CHAN);
  wire sel_pins = reg_hit(addr_i, dac_pkg::REG_PINS);
  wire wr_chan  = wr_i & sel_chan;
  wire wr_pins  = wr_i & sel_pins;

  // Read data views of both registers
  wire [7:0] chan_view = {lock_o, 5'h00, rev_chan_enable, fwd_chan_enable};
  wire [7:0] pins_view = {skew_disable, 3'h0, pin1_drive, pin1_level, pin0_drive, pin0_level};
  wire [7:0] next_rdata = sel_chan ? chan_view : (sel_pins ? pins_view : 8'h00);

  // Dual-controller mode and side-select change detection
  wire dual_mode   = ~ser_side_select_i & host_side_select_i;              // [R1]
  wire side_change = (ser_side_select_i != ser_sel_q) | (host_side_select_i != host_sel_q);
  // Only a change away from dual mode asks for a restart; other modes start alone
  wire dual_was    = ~ser_sel_q & host_sel_q;

  // Reverse hold-off after link start or stop
  wire link_edge = (link_active_i != link_q);
  assign next_hold_cnt = link_edge ? HOLD_LOAD :                           // [R5]
                         ((hold_cnt != '0) ? hold_cnt - HW'(1) : hold_cnt);
  // A link edge inside the hold-off reloads it, so the whole wait is served again
  wire rev_ok = rev_chan_enable & link_active_i & (hold_cnt == '0);        // [R5]

  // Registers written by software
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fwd_chan_enable <= dac_pkg::RST_FWD_EN;                              // [R17]
      rev_chan_enable <= dac_pkg::RST_REV_EN;                              // [R17]
      pin0_drive      <= dac_pkg::RST_DRIVE;                               // [R16]
      pin1_drive      <= dac_pkg::RST_DRIVE;                               // [R16]
      skew_disable    <= dac_pkg::RST_SKEW_DIS;                            // [R13]
    end else if (wr_chan) begin
      fwd_chan_enable <= wdata_i[dac_pkg::BIT_FWD_EN];                     // [R3]
      rev_chan_enable <= wdata_i[dac_pkg::BIT_REV_EN];                     // [R3]
    end else if (wr_pins) begin
      pin0_drive      <= wdata_i[dac_pkg::BIT_P0_DRIVE];                   // [R10]
      pin1_drive      <= wdata_i[dac_pkg::BIT_P1_DRIVE];                   // [R10]
      skew_disable    <= wdata_i[dac_pkg::BIT_SKEW_DIS];                   // [R13]
    end
  end

  // Read port: data stand in the cycle after the strobe only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end

  // Pin sampling, always enabled so levels are valid while driving too
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin0_level <= 1'b1;
      pin1_level <= 1'b1;
    end else begin
      pin0_level <= pin0_i;                                                // [R11]
      pin1_level <= pin1_i;                                                // [R11]
    end
  end

  // Open drain: only ever pull low, release means tristate
  assign pin0_o    = 1'b0;
  assign pin1_o    = 1'b0;
  assign pin0_oe_o = ~pin0_drive;                                          // [R10]
  assign pin1_oe_o = ~pin1_drive;                                          // [R10]

  // Link status, side-select history and hold counter
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ser_sel_q   <= 1'b0;
      host_sel_q  <= 1'b0;
      link_q      <= 1'b0;
      hold_cnt    <= '0;
      dual_mode_o <= 1'b0;
      restart_o   <= 1'b0;
      lock_o      <= 1'b0;
      rev_int_o   <= 1'b0;
      rev_avail_o <= 1'b0;
    end else begin
      ser_sel_q   <= ser_side_select_i;
      host_sel_q  <= host_side_select_i;
      link_q      <= link_active_i;
      hold_cnt    <= next_hold_cnt;
      dual_mode_o <= dual_mode;                                            // [R1]
      restart_o   <= side_change & dual_was;                               // [R4]
      lock_o      <= video_locked_i;                                       // [R8]
      rev_int_o   <= int_i;                                                // [R9]
      rev_avail_o <= (link_edge ? 1'b0 : rev_ok);                          // [R5]
    end
  end

  // Control UART paths; idle level is high. Both directions run together with
  // no arbitration and no acknowledge, so a collision is simply corrupted.
  // A 25 ns sample is far finer than a 1 us bit, so 1 Mbps passes cleanly.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fwd_uart_o <= 1'b1;
      rev_uart_o <= 1'b1;
    end else begin
      fwd_uart_o <= fwd_chan_enable ? fwd_uart_i : 1'b1;                   // [R3] [R2] [R15]
      rev_uart_o <= (rev_ok & ~link_edge) ? rev_uart_i : 1'b1;             // [R3] [R5] [R1]
    end
  end

  // Output stagger codes; actual delay cells sit in the pad ring
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      skew_o <= '{dac_pkg::SKEW_G0, dac_pkg::SKEW_G1, dac_pkg::SKEW_G2,
                  dac_pkg::SKEW_G3, dac_pkg::SKEW_PCLK};
    end else if (skew_disable) begin
      skew_o <= '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0};                           // [R14]
    end else begin
      skew_o <= '{dac_pkg::SKEW_G0, dac_pkg::SKEW_G1, dac_pkg::SKEW_G2,
                  dac_pkg::SKEW_G3, dac_pkg::SKEW_PCLK};                   // [R14]
    end
  end

  // Checks
  sequence chan_cleared_s;
    wr_i && sel_chan && (wdata_i[1:0] == 2'b00);
  endsequence

  sequence pins_read_s;
    rd_i && sel_pins;
  endsequence

  sequence side_left_s;
    dual_mode ##1 ((ser_side_select_i != $past(ser_side_select_i)) ||
                   (host_side_select_i != $past(host_side_select_i)));
  endsequence

  sequence skew_enabled_s;
    wr_i && sel_pins && !wdata_i[dac_pkg::BIT_SKEW_DIS] ##1 !wr_i;
  endsequence

  lock_video_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R8]
    (config_link_i && !video_locked_i) |=> !lock_o)
    else $error("lock asserted without video lock");

  rev_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R5]
    (link_active_i != $past(link_active_i)) |=> (hold_cnt == HOLD_LOAD) && !rev_avail_o)
    else $error("reverse hold-off not started");

  rev_blocked_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R5]
    (hold_cnt != '0) |=> rev_uart_o)
    else $error("reverse traffic during hold-off");

  chan_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R3]
    chan_cleared_s ##1 (!wr_i)[*2] |-> fwd_uart_o && rev_uart_o)
    else $error("channel traffic after enables cleared");

  side_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R4]
    side_left_s |=> restart_o)
    else $error("no restart on side-select change");

  int_mirror_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R9]
    $rose(int_i) |=> rev_int_o)
    else $error("interrupt not mirrored");

  pin_release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R10]
    (wr_i && sel_pins && wdata_i[dac_pkg::BIT_P1_DRIVE]) |=> !pin1_oe_o)
    else $error("pin1 still driven after release");

  pin_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R11]
    pins_read_s |=> rdata_o[dac_pkg::BIT_P0_LEVEL] == $past(pin0_level))
    else $error("pin0 level misread");

  skew_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R14]
    (wr_i && sel_pins && wdata_i[dac_pkg::BIT_SKEW_DIS]) ##1 !wr_i |=> skew_o == '0)
    else $error("skew not removed");

  dual_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R1]
    (!ser_side_select_i && host_side_select_i) |=> dual_mode_o)
    else $error("dual mode not flagged");

  // Further checks: restart pulse, hold-off, gating, pass-through and pins
  restart_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R4]
    restart_o |=> !restart_o)
    else $error("restart held longer than one cycle");

  dual_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R1]
    !(!ser_side_select_i && host_side_select_i) |=> !dual_mode_o)
    else $error("dual mode flagged outside dual selection");

  rev_avail_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R5]
    rev_avail_o |-> (hold_cnt == '0) && link_q)
    else $error("reverse channel offered during hold-off");

  hold_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R5]
    (hold_cnt != '0) && !link_edge |=> hold_cnt == $past(hold_cnt) - HW'(1))
    else $error("hold-off counter not counting down");

  fwd_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R3]
    !fwd_chan_enable |=> fwd_uart_o)
    else $error("forward traffic while disabled");

  rev_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R3]
    !rev_chan_enable |=> rev_uart_o)
    else $error("reverse traffic while disabled");

  fwd_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R2]
    fwd_chan_enable |=> fwd_uart_o == $past(fwd_uart_i))
    else $error("forward bit not passed through");

  rev_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R1]
    rev_ok && !link_edge |=> rev_uart_o == $past(rev_uart_i))
    else $error("reverse bit not passed through");

  lock_follow_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R8]
    video_locked_i |=> lock_o)
    else $error("lock not reported with video lock");

  int_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R9]
    $fell(int_i) |=> !rev_int_o)
    else $error("interrupt release not mirrored");

  pin_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R10]
    (wr_i && sel_pins && !wdata_i[dac_pkg::BIT_P0_DRIVE]) |=> pin0_oe_o)
    else $error("pin0 not pulled low");

  pin_level_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R11]
    $changed(pin1_i) |=> pin1_level == $past(pin1_i))
    else $error("pin1 level not sampled");

  skew_on_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R13]
    skew_enabled_s |=> skew_o == {dac_pkg::SKEW_G0, dac_pkg::SKEW_G1, dac_pkg::SKEW_G2,
                                  dac_pkg::SKEW_G3, dac_pkg::SKEW_PCLK})
    else $error("skew not restored");

endmodule : dac_aux_control
`default_nettype wire

// >>> dac_partner.sv
`default_nettype none
module dac_partner (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic link_req_i,
  input  wire logic ext0_low_i,
  input  wire logic ext1_low_i,
  input  wire logic pin0_oe_i,
  input  wire logic pin1_oe_i,
  output logic      link_active_o,
  output logic      fwd_bit_o,
  output logic      pin0_lvl_o,
  output logic      pin1_lvl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Last tick of a bit at the fast and slow rates: 2 and 6 clocks, a step of 3
  localparam logic [2:0] FAST_LAST = 3'h1;
  localparam logic [2:0] SLOW_LAST = 3'h5;
  logic [2:0] tick;
  logic [3:0] bits_sent;
  logic       slow;

  // Pads have pull-ups; low when the device or an outside driver sinks them
  assign pin0_lvl_o = (pin0_oe_i || ext0_low_i) ? 1'b0 : 1'b1;
  assign pin1_lvl_o = (pin1_oe_i || ext1_low_i) ? 1'b0 : 1'b1;

  // Far serializer: link follows its request, forward stream idles high when down;
  // the bit rate steps between fast and slow every 16 bits, never by 3.5 or more
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick <= 3'h0;
      bits_sent <= 4'h0;
      slow <= 1'b0;
      link_active_o <= 1'b0;
      fwd_bit_o <= 1'b1;
    end else begin
      link_active_o <= link_req_i;
      if (!link_active_o) begin
        tick <= 3'h0;
        fwd_bit_o <= 1'b1;
      end else if (tick == (slow ? SLOW_LAST : FAST_LAST)) begin
        tick <= 3'h0;
        fwd_bit_o <= ~fwd_bit_o;
        bits_sent <= bits_sent + 4'h1;
        if (bits_sent == 4'hF) slow <= ~slow;
      end else begin
        tick <= tick + 3'h1;
      end
    end
  end
endmodule : dac_partner
`default_nettype wire

// >>> test_dac_aux_control.sv
`default_nettype none
module test_dac_aux_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, sys_rst, wr, rd, ser_sel, host_sel, link_req, video_locked, config_link;
  logic       int_in, rev_in, ext0, ext1, dual, restart, link_active, lock, rev_int, rev_avail;
  logic       fwd_bit, fwd_out, rev_out, p0_lvl, p1_lvl, p0_o, p1_o, p0_oe, p1_oe;
  logic [7:0] addr, wdata, rdata, seen;
  int         failures, check_count, n;
  dac_pkg::dac_skew_type skew;
  localparam logic [14:0] SKEW_ON = {dac_pkg::SKEW_G0, dac_pkg::SKEW_G1, dac_pkg::SKEW_G2,
                                     dac_pkg::SKEW_G3, dac_pkg::SKEW_PCLK};

  // Short hold-off keeps the run brief
  dac_aux_control #(.REV_HOLD_CYC(20)) i_dut (
    .clk_i(clk), .sys_rst_i(sys_rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .ser_side_select_i(ser_sel), .host_side_select_i(host_sel),
    .dual_mode_o(dual), .restart_o(restart), .link_active_i(link_active),
    .video_locked_i(video_locked), .config_link_i(config_link), .lock_o(lock),
    .int_i(int_in), .rev_int_o(rev_int), .rev_avail_o(rev_avail), .fwd_uart_i(fwd_bit),
    .fwd_uart_o(fwd_out), .rev_uart_i(rev_in), .rev_uart_o(rev_out), .pin0_i(p0_lvl),
    .pin0_o(p0_o), .pin0_oe_o(p0_oe), .pin1_i(p1_lvl), .pin1_o(p1_o), .pin1_oe_o(p1_oe),
    .skew_o(skew));
  dac_partner i_far (
    .clk_i(clk), .rst_i(sys_rst), .link_req_i(link_req),
    .ext0_low_i(ext0), .ext1_low_i(ext1),
    .pin0_oe_i(p0_oe), .pin1_oe_i(p1_oe), .link_active_o(link_active),
    .fwd_bit_o(fwd_bit), .pin0_lvl_o(p0_lvl), .pin1_lvl_o(p1_lvl));

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Let updates of the edge settle before looking
  task automatic look(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : look

  task automatic print_verdict;
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    {sys_rst, ser_sel, host_sel, rev_in} = 4'hF;
    {wr, rd, link_req, video_locked, config_link, int_in, ext0, ext1} = 8'h00;
    {addr, wdata} = 16'h0000;
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    look(4);
    check({p1_oe, p0_oe}, 2'h0);
    check({p1_o, p0_o}, 2'h0);
    check(skew, SKEW_ON);
    rd_reg(8'h04, seen); check(seen, 8'h03);
    rd_reg(8'h06, seen); check(seen, 8'h0F);
    rd_reg(8'h00, seen); check(seen, 8'h00);
    wr_reg(8'h06, 8'h8F); look(2); check(skew, 15'h0000);
    wr_reg(8'h06, 8'h0F); look(2); check(skew, SKEW_ON);
    // Both pins pulled low; written level bits are ignored
    wr_reg(8'h06, 8'h05); look(4); check({p1_oe, p0_oe, p1_lvl, p0_lvl}, 4'hC);
    rd_reg(8'h06, seen); check(seen, 8'h00);
    // Released pin used as input while an outside driver sinks pin 1
    wr_reg(8'h06, 8'h0A);
    @(posedge clk) ext1 <= 1'b1;
    look(4); check({p1_oe, p0_oe}, 2'h0);
    rd_reg(8'h06, seen); check(seen, 8'h0B);
    @(posedge clk) video_locked <= 1'b1;
    look(3); check(lock, 1'b1);
    rd_reg(8'h04, seen); check(seen, 8'h83);
    @(posedge clk) {video_locked, config_link} <= 2'h1;
    look(3); check(lock, 1'b0);
    // Loopback with the link down
    @(posedge clk) int_in <= 1'b1;
    look(2); check(rev_int, 1'b1);
    @(posedge clk) int_in <= 1'b0;
    look(2); check(rev_int, 1'b0);
    // Dual mode, link start; host talks too early on purpose
    @(posedge clk) {ser_sel, link_req, rev_in} <= 3'h2;
    look(2); check(dual, 1'b1);
    n = 0;
    while (rev_avail !== 1'b1 && n < 60) begin
      if (n == 5) check(rev_out, 1'b1);
      look(1);
      n++;
    end
    if (n == 60) begin
      failures++;
      print_verdict;
    end
    check(n >= 16 && n <= 26, 1'b1);
    look(1); check(rev_out, 1'b0);
    repeat (8) begin
      seen[0] = fwd_bit;
      look(1); check(fwd_out, seen[0]);
    end
    wr_reg(8'h04, 8'h00);
    repeat (6) begin
      look(1); check({fwd_out, rev_out}, 2'h3);
    end
    wr_reg(8'h04, 8'h83); rd_reg(8'h04, seen); check(seen, 8'h03);
    // Link stop restarts the hold-off
    @(posedge clk) link_req <= 1'b0;
    look(3); check(rev_avail, 1'b0);
    @(posedge clk) ser_sel <= 1'b1;
    n = 0;
    while (restart !== 1'b1 && n < 4) begin
      look(1);
      n++;
    end
    check(n < 4, 1'b1);
    look(1); check({restart, dual}, 2'h0);
    // Back to dual, then the own side-select drops
    @(posedge clk) ser_sel <= 1'b0;
    look(2); check(dual, 1'b1);
    @(posedge clk) host_sel <= 1'b0;
    look(1); check(restart, 1'b1);
    look(1); check({restart, dual}, 2'h0);
    print_verdict;
  end
endmodule : test_dac_aux_control
`default_nettype wire
